/* rtl/ceb_pkg.sv */
// package of the error capture and bit-rate block: offsets, fields, resets
// assumes a 32-bit register port with byte addresses
package ceb_pkg;
    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] CAPTURE_OFS = 8'h20;
    localparam logic [7:0] STATUS_OFS = 8'h40;
    localparam logic [7:0] CLEAR_OFS = 8'h44;
    localparam logic [7:0] ENABLE_OFS = 8'h48;
    localparam logic [7:0] TIMING_OFS = 8'h50;
    // ---------------------------------------------------------------
    // capture register fields
    // ---------------------------------------------------------------
    localparam int LONG_IDENT_MISMATCH_POS = 6;
    localparam int SHORT_IDENT_MISMATCH_POS = 5;
    localparam int STUFFING_VIOLATION_POS = 4;
    localparam int FIXED_FIELD_VIOLATION_POS = 3;
    localparam int CHECKSUM_MISMATCH_POS = 2;
    localparam int MISSING_ACKNOWLEDGE_POS = 1;
    localparam int READBACK_MISMATCH_POS = 0;
    localparam int EVENT_COUNT = 5;
    localparam logic [31:0] CAPTURE_RST = 32'h0000_0000;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [4:0] ENABLE_RST = 5'h00;
    // ---------------------------------------------------------------
    // timing register fields
    // ---------------------------------------------------------------
    localparam int PRE_SAMPLE_LSB = 6;
    localparam int PRE_SAMPLE_W = 5;
    localparam int POST_SAMPLE_LSB = 11;
    localparam int POST_SAMPLE_W = 4;
    localparam int DIVIDER_LSB = 16;
    localparam int DIVIDER_W = 8;
    localparam logic [31:0] TIMING_RST = 32'h0000_1100;
    localparam logic [31:0] TIMING_MASK = 32'h00FF_7FC0;
    // ---------------------------------------------------------------
    // frame checks
    // ---------------------------------------------------------------
    localparam logic [2:0] STUFF_LIMIT = 3'h6;
    localparam logic [14:0] CRC_POLY = 15'h4599;
endpackage : ceb_pkg

/* rtl/ceb_bit_timer.sv */
// bit timer: time quanta from the divider, sample point and bit end
// assumes settings held stable by software while the bus is in use
`timescale 1ns/10ps
`default_nettype none
module ceb_bit_timer #(
    parameter int DIV_W = 8,
    parameter int SEG1_W = 5,
    parameter int SEG2_W = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [DIV_W-1:0] divider,
    input wire logic [SEG1_W-1:0] pre_sample_segment,
    input wire logic [SEG2_W-1:0] post_sample_segment,
    output logic sample_pulse,
    output logic bit_end_pulse
);
    localparam int TQ_W = SEG1_W + 2;
    if (DIV_W < 1 || SEG1_W < 2 || SEG2_W < 1 ||
        SEG2_W > SEG1_W) begin : g_bad_widths
        $error("ceb_bit_timer: unsupported widths");
    end
    logic [DIV_W-1:0] quant_reg, quant_next;
    logic [TQ_W-1:0] tq_reg, tq_next;
    logic sample_reg, sample_next;
    logic bit_end_reg, bit_end_next;
    logic [TQ_W-1:0] last_tq;
    logic [TQ_W-1:0] sample_tq;
    logic quant_end;
    // ---------------------------------------------------------------
    // quantum and segment counters
    // ---------------------------------------------------------------
    always_comb begin
        // bit = sync + (seg1+1) + (seg2+1) quanta, i.e. seg1+seg2+3
        last_tq = TQ_W'(pre_sample_segment) + TQ_W'(post_sample_segment)
            + TQ_W'(2); // RULE1
        // sample after sync plus seg1+1 quanta
        sample_tq = TQ_W'(pre_sample_segment) + TQ_W'(1); // RULE2
        quant_end = (quant_reg == divider); // RULE1
        quant_next = quant_end ? '0 : quant_reg + DIV_W'(1);
        tq_next = tq_reg;
        if (quant_end) begin
            tq_next = (tq_reg >= last_tq) ? '0 : tq_reg + TQ_W'(1);
        end
        sample_next = quant_end && (tq_reg == sample_tq); // RULE2
        bit_end_next = quant_end && (tq_reg >= last_tq);
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            quant_reg <= '0;
            tq_reg <= '0;
            sample_reg <= 1'b0;
            bit_end_reg <= 1'b0;
        end else begin
            quant_reg <= quant_next;
            tq_reg <= tq_next;
            sample_reg <= sample_next;
            bit_end_reg <= bit_end_next;
        end
    end
    assign sample_pulse = sample_reg;
    assign bit_end_pulse = bit_end_reg;
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    bit_spacing_a: assert property ( // RULE1
        @(posedge core_clk) disable iff (rst)
        quant_end && tq_reg == last_tq |=> bit_end_pulse)
        else $error("bit end not flagged after last quantum");
    sample_spacing_a: assert property ( // RULE2
        @(posedge core_clk) disable iff (rst)
        sample_pulse |-> $past(tq_reg) == $past(sample_tq))
        else $error("sample point at wrong quantum");
endmodule : ceb_bit_timer
`default_nettype wire

/* rtl/ceb_error_capture.sv */
// error capture and bit-rate top: checks bus bits at the sample point and
// records protocol errors and identifier mismatch for software
// assumes the frame engine drives the field strobes on core_clk
//
// Function
// RULE1 - bit rate is clock over (divider+1) times (seg1+seg2+3).
// RULE2 - seg1+1 quanta lead from sync to sample, seg2+1 follow it.
// RULE3 - bit 6 shows whether the 18-bit identifier pattern mismatched.
// RULE4 - bit 5 shows whether the 11-bit identifier pattern mismatched.
// RULE5 - both identifier flags update only on a CRC error; writing 0 clears.
// RULE6 - bit 4 flags the sixth equal bit in a stuffed field.
// RULE7 - bit 3 flags an illegal bit in a fixed-form field.
// RULE8 - bit 2 flags a received CRC differing from the computed one.
// RULE9 - bit 1 flags a recessive acknowledge slot while sending.
// RULE10 - bit 0 flags a monitored bit differing from the sent bit.
// RULE11 - bits 31 to 7 of the capture register read zero, writes ignored.
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module ceb_error_capture (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic can_rx_pin,
    input wire logic tx_level,
    input wire logic transmitting,
    input wire logic frame_start,
    input wire logic stuffed_field,
    input wire logic fixed_field,
    input wire logic ack_slot,
    input wire logic bit_check_en,
    input wire logic crc_calc_en,
    input wire logic crc_recv_en,
    input wire logic crc_check,
    input wire logic id11_field,
    input wire logic id18_field,
    input wire logic [10:0] id11_pattern,
    input wire logic [17:0] id18_pattern,
    output logic sample_point,
    output logic bit_end,
    output logic rx_level
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [14:0] crc_step(input logic [14:0] crc,
                                             input logic din);
        logic [14:0] sh;
        sh = {crc[13:0], 1'b0};
        crc_step = (din ^ crc[14]) ? (sh ^ ceb_pkg::CRC_POLY) : sh;
    endfunction : crc_step

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ---------------------------------------------------------------
    // pin synchroniser
    // ---------------------------------------------------------------
    logic [2:0] sync_reg, sync_next;
    logic rx_reg, rx_next;
    always_comb begin
        sync_next = {sync_reg[1:0], can_rx_pin};
        // a change counts once stages two and three agree
        rx_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : rx_reg;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync_reg <= 3'h7;
            rx_reg <= 1'b1;
        end else begin
            sync_reg <= sync_next;
            rx_reg <= rx_next;
        end
    end
    assign rx_level = rx_reg;

    // ---------------------------------------------------------------
    // bit timing
    // ---------------------------------------------------------------
    logic [31:0] timing_reg, timing_next;
    logic sample_pulse;
    ceb_bit_timer #(
        .DIV_W(ceb_pkg::DIVIDER_W),
        .SEG1_W(ceb_pkg::PRE_SAMPLE_W),
        .SEG2_W(ceb_pkg::POST_SAMPLE_W)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .divider(timing_reg[ceb_pkg::DIVIDER_LSB +: ceb_pkg::DIVIDER_W]),
        .pre_sample_segment(
            timing_reg[ceb_pkg::PRE_SAMPLE_LSB +: ceb_pkg::PRE_SAMPLE_W]),
        .post_sample_segment(
            timing_reg[ceb_pkg::POST_SAMPLE_LSB +: ceb_pkg::POST_SAMPLE_W]),
        .sample_pulse(sample_pulse),
        .bit_end_pulse(bit_end)
    );
    assign sample_point = sample_pulse;

    // ---------------------------------------------------------------
    // frame checks at the sample point
    // ---------------------------------------------------------------
    logic [2:0] stuff_cnt_reg, stuff_cnt_next;
    logic last_bit_reg, last_bit_next;
    logic [14:0] crc_calc_reg, crc_calc_next;
    logic [14:0] crc_rx_reg, crc_rx_next;
    logic [10:0] id11_rx_reg, id11_rx_next;
    logic [17:0] id18_rx_reg, id18_rx_next;
    logic [4:0] ev;
    logic [2:0] run_len;
    always_comb begin
        stuff_cnt_next = stuff_cnt_reg;
        last_bit_next = last_bit_reg;
        crc_calc_next = crc_calc_reg;
        crc_rx_next = crc_rx_reg;
        id11_rx_next = id11_rx_reg;
        id18_rx_next = id18_rx_reg;
        ev = 5'h00;
        run_len = (rx_reg == last_bit_reg) ? stuff_cnt_reg + 3'h1 : 3'h1;
        if (frame_start) begin
            stuff_cnt_next = 3'h0;
            crc_calc_next = 15'h0000;
            crc_rx_next = 15'h0000;
        end else if (sample_pulse) begin
            last_bit_next = rx_reg;
            if (stuffed_field) begin
                // restart the run after a violation so it is flagged once
                stuff_cnt_next = (run_len == ceb_pkg::STUFF_LIMIT) ?
                    3'h1 : run_len;
                ev[ceb_pkg::STUFFING_VIOLATION_POS] =
                    (run_len == ceb_pkg::STUFF_LIMIT); // RULE6
            end else begin
                stuff_cnt_next = 3'h0;
            end
            if (crc_calc_en) begin
                crc_calc_next = crc_step(crc_calc_reg, rx_reg); // RULE8
            end
            if (crc_recv_en) begin
                crc_rx_next = {crc_rx_reg[13:0], rx_reg};
            end
            if (id11_field) begin
                id11_rx_next = {id11_rx_reg[9:0], rx_reg};
            end
            if (id18_field) begin
                id18_rx_next = {id18_rx_reg[16:0], rx_reg};
            end
            // fixed-form fields are all recessive
            ev[ceb_pkg::FIXED_FIELD_VIOLATION_POS] =
                fixed_field && !rx_reg; // RULE7
            ev[ceb_pkg::CHECKSUM_MISMATCH_POS] =
                crc_check && (crc_calc_reg != crc_rx_reg); // RULE8
            ev[ceb_pkg::MISSING_ACKNOWLEDGE_POS] =
                transmitting && ack_slot && rx_reg; // RULE9
            // the ack slot is sent recessive and may read dominant
            ev[ceb_pkg::READBACK_MISMATCH_POS] = transmitting &&
                bit_check_en && !ack_slot && (rx_reg != tx_level); // RULE10
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stuff_cnt_reg <= 3'h0;
            last_bit_reg <= 1'b1;
            crc_calc_reg <= 15'h0000;
            crc_rx_reg <= 15'h0000;
            id11_rx_reg <= 11'h000;
            id18_rx_reg <= 18'h00000;
        end else begin
            stuff_cnt_reg <= stuff_cnt_next;
            last_bit_reg <= last_bit_next;
            crc_calc_reg <= crc_calc_next;
            crc_rx_reg <= crc_rx_next;
            id11_rx_reg <= id11_rx_next;
            id18_rx_reg <= id18_rx_next;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [6:0] capture_reg, capture_next;
    logic [4:0] status_reg, status_next;
    logic [4:0] enable_reg, enable_next;
    logic [31:0] rdata_reg, rdata_next;
    logic crc_ev;
    logic cap_wr;
    always_comb begin
        crc_ev = ev[ceb_pkg::CHECKSUM_MISMATCH_POS];
        cap_wr = reg_wr && hit(reg_addr, ceb_pkg::CAPTURE_OFS);
        capture_next = capture_reg;
        // writing 0 clears a bit; upper bits are never stored
        if (cap_wr) begin
            capture_next = capture_reg & reg_wdata[6:0]; // RULE5 RULE11
        end
        // a new error replaces bits 4 to 0 of the record; set wins over a clear
        if (|ev) begin
            capture_next[4:0] = ev;
        end
        if (crc_ev) begin
            capture_next[ceb_pkg::LONG_IDENT_MISMATCH_POS] =
                (id18_rx_reg != id18_pattern); // RULE3 RULE5
            capture_next[ceb_pkg::SHORT_IDENT_MISMATCH_POS] =
                (id11_rx_reg != id11_pattern); // RULE4 RULE5
        end
        status_next = status_reg;
        if (reg_wr && hit(reg_addr, ceb_pkg::CLEAR_OFS)) begin
            status_next = status_reg & ~reg_wdata[4:0];
        end
        status_next = status_next | ev;
        enable_next = enable_reg;
        if (reg_wr && hit(reg_addr, ceb_pkg::ENABLE_OFS)) begin
            enable_next = reg_wdata[4:0];
        end
        timing_next = timing_reg;
        if (reg_wr && hit(reg_addr, ceb_pkg::TIMING_OFS)) begin
            timing_next = reg_wdata & ceb_pkg::TIMING_MASK;
        end
        rdata_next = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                ceb_pkg::CAPTURE_OFS: rdata_next = {25'h0, capture_reg};
                ceb_pkg::STATUS_OFS: rdata_next = {27'h0, status_reg};
                ceb_pkg::ENABLE_OFS: rdata_next = {27'h0, enable_reg};
                ceb_pkg::TIMING_OFS: rdata_next = timing_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            capture_reg <= ceb_pkg::CAPTURE_RST[6:0];
            status_reg <= ceb_pkg::STATUS_RST;
            enable_reg <= ceb_pkg::ENABLE_RST;
            timing_reg <= ceb_pkg::TIMING_RST;
            rdata_reg <= 32'h0000_0000;
        end else begin
            capture_reg <= capture_next;
            status_reg <= status_next;
            enable_reg <= enable_next;
            timing_reg <= timing_next;
            rdata_reg <= rdata_next;
        end
    end
    assign reg_rdata = rdata_reg;
    assign irq = |(status_reg & enable_reg);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    stuff_run_a: assert property ( // RULE6
        sample_pulse && !frame_start && stuffed_field &&
        stuff_cnt_reg == 3'h5 && rx_reg == last_bit_reg
        |=> capture_reg[4] && status_reg[4])
        else $error("sixth equal bit not flagged");
    stuff_quiet_a: assert property ( // RULE6
        sample_pulse && stuffed_field && stuff_cnt_reg < 3'h4
        |=> !$rose(status_reg[4]))
        else $error("stuff error before sixth bit");
    fixed_form_a: assert property ( // RULE7
        sample_pulse && !frame_start && fixed_field && !rx_reg
        |=> capture_reg[3])
        else $error("fixed field violation missed");
    crc_compare_a: assert property ( // RULE8
        sample_pulse && !frame_start && crc_check &&
        crc_calc_reg != crc_rx_reg |=> capture_reg[2] ##1 status_reg[2])
        else $error("crc mismatch not recorded");
    ack_missing_a: assert property ( // RULE9
        sample_pulse && !frame_start && transmitting && ack_slot && rx_reg
        |=> capture_reg[1])
        else $error("missing acknowledge not flagged");
    readback_diff_a: assert property ( // RULE10
        sample_pulse && !frame_start && transmitting && bit_check_en &&
        !ack_slot && rx_reg != tx_level |=> capture_reg[0])
        else $error("readback mismatch not flagged");
    long_ident_a: assert property ( // RULE3
        crc_ev |=> capture_reg[6] ==
            ($past(id18_rx_reg) != $past(id18_pattern)))
        else $error("long identifier flag wrong");
    short_ident_a: assert property ( // RULE4
        crc_ev |=> capture_reg[5] ==
            ($past(id11_rx_reg) != $past(id11_pattern)))
        else $error("short identifier flag wrong");
    ident_hold_a: assert property ( // RULE5
        !crc_ev && !cap_wr |=> $stable(capture_reg[6:5]))
        else $error("identifier flags changed without cause");
    reserved_zero_a: assert property ( // RULE11
        reg_rd && reg_addr == ceb_pkg::CAPTURE_OFS |=> reg_rdata[31:7] == 0)
        else $error("reserved capture bits not zero");

    ack_err_c: cover property (
        sample_pulse && transmitting && ack_slot && rx_reg);
    crc_ident_c: cover property (crc_ev && id18_rx_reg != id18_pattern);
    stuff_err_c: cover property (ev[4] ##[1:100] irq);
endmodule : ceb_error_capture
`default_nettype wire

/* tb/ceb_bus_node.sv */
// model of the other nodes on the shared bus, seen as one wired-and party
// assumes the bench commands when the other nodes pull the bus dominant
`timescale 1ns/10ps
`default_nettype none
module ceb_bus_node (
    input wire logic transmitting,
    input wire logic tx_level,
    input wire logic node_dom,
    output logic can_rx_pin
);
    // ---------------------------------------------------------------
    // wired-and bus, pull-up makes a released bus recessive
    // ---------------------------------------------------------------
    // dominant from any party wins, so a sender may read back a 0
    assign can_rx_pin = (transmitting ? tx_level : 1'b1) &
        ~node_dom;
endmodule : ceb_bus_node
`default_nettype wire

/* tb/ceb_error_capture_tb.sv */
// bench of the error capture and bit-rate block
// assumes the bench plays the frame engine and the register master
`timescale 1ns/10ps
`default_nettype none
module ceb_error_capture_tb;
    // ---------------------------------------------------------------
    // signals and qualifier codes
    // ---------------------------------------------------------------
    localparam logic [8:0] QS = 9'h100;
    localparam logic [8:0] QF = 9'h080;
    localparam logic [8:0] QA = 9'h040;
    localparam logic [8:0] QB = 9'h020;
    localparam logic [8:0] QC = 9'h010;
    localparam logic [8:0] QR = 9'h008;
    localparam logic [8:0] QK = 9'h004;
    localparam logic [8:0] Q11 = 9'h002;
    localparam logic [8:0] Q18 = 9'h001;
    logic core_clk, rst, reg_wr, reg_rd, irq, frame_start;
    logic tx_level, transmitting, node_dom, can_rx_pin;
    logic stuffed_field, fixed_field, ack_slot, bit_check_en;
    logic crc_calc_en, crc_recv_en, crc_check, id11_field, id18_field;
    logic sample_point, bit_end, rx_level;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [8:0] q;
    logic [10:0] id11_pattern;
    logic [17:0] id18_pattern;
    int err_count, n_checks, cyc;
    assign {stuffed_field, fixed_field, ack_slot, bit_check_en, crc_calc_en,
            crc_recv_en, crc_check, id11_field, id18_field} = q;

    ceb_error_capture u_dut (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .can_rx_pin(can_rx_pin), .tx_level(tx_level),
        .transmitting(transmitting), .frame_start(frame_start),
        .stuffed_field(stuffed_field), .fixed_field(fixed_field),
        .ack_slot(ack_slot), .bit_check_en(bit_check_en),
        .crc_calc_en(crc_calc_en), .crc_recv_en(crc_recv_en),
        .crc_check(crc_check), .id11_field(id11_field),
        .id18_field(id18_field), .id11_pattern(id11_pattern),
        .id18_pattern(id18_pattern), .sample_point(sample_point),
        .bit_end(bit_end), .rx_level(rx_level));
    ceb_bus_node u_node (.transmitting(transmitting), .tx_level(tx_level),
        .node_dom(node_dom), .can_rx_pin(can_rx_pin));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(reg_rdata, e);
    endtask : rd
    // waits for the edge that ends a bit (0) or a sample point (1)
    task wt(input logic s);
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (((s ? sample_point : bit_end) !== 1'b1) && k < 1000);
        if (k >= 1000) check(32'h0, 32'h1);
    endtask : wt
    // one bus bit: qualifiers held for the whole bit
    task sb(input logic l, input logic d, input logic [8:0] qq,
            input logic t);
        wt(1'b0);
        tx_level <= l;
        node_dom <= d;
        q <= qq;
        transmitting <= t;
        wt(1'b1);
        @(negedge core_clk);
        check({31'h0, rx_level}, {31'h0, (l | ~t) & ~d});
    endtask : sb
    task fstart;
        wt(1'b0);
        frame_start <= 1'b1;
        @(posedge core_clk);
        frame_start <= 1'b0;
    endtask : fstart
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task t_regs;
        rd(ceb_pkg::CAPTURE_OFS, 32'h0000_0000);
        rd(ceb_pkg::STATUS_OFS, 32'h0000_0000);
        rd(ceb_pkg::TIMING_OFS, 32'h0000_1100);
        rd(ceb_pkg::CLEAR_OFS, 32'h0000_0000);
        rd(8'h3C, 32'h0000_0000);
    endtask : t_regs
    task t_stuff;
        fstart();
        repeat (5) sb(1'b1, 1'b0, QS, 1'b0);
        rd(ceb_pkg::CAPTURE_OFS, 32'h0000_0000);
        sb(1'b1, 1'b0, QS, 1'b0);
        sb(1'b1, 1'b0, 9'h000, 1'b0);
        rd(ceb_pkg::CAPTURE_OFS, 32'h0000_0010);
        rd(ceb_pkg::STATUS_OFS, 32'h0000_0010);
        wr(ceb_pkg::ENABLE_OFS, 32'h0000_0010);
        @(negedge core_clk);
        check({31'h0, irq}, 32'h1);
        rd(ceb_pkg::ENABLE_OFS, 32'h0000_0010);
        wr(ceb_pkg::ENABLE_OFS, 32'h0000_0000);
        @(negedge core_clk);
        check({31'h0, irq}, 32'h0);
        wr(ceb_pkg::ENABLE_OFS, 32'h0000_0010);
        wr(ceb_pkg::CLEAR_OFS, 32'h0000_0010);
        @(negedge core_clk);
        check({31'h0, irq}, 32'h0);
        rd(ceb_pkg::STATUS_OFS, 32'h0000_0000);
        wr(ceb_pkg::CAPTURE_OFS, 32'hFFFF_FFFF);
        rd(ceb_pkg::CAPTURE_OFS, 32'h0000_0010);
        wr(ceb_pkg::CAPTURE_OFS, 32'h0000_0000);
        rd(ceb_pkg::CAPTURE_OFS, 32'h0000_0000);
    endtask : t_stuff
    // form, acknowledge and readback cases, each with and without fault
    task t_events;
        logic [5:0] tl, td, tt;
        logic [8:0] tq [6];
        logic [3:0] te [6];
        tl = 6'b011111;
        td = 6'b111001;
        tt = 6'b111100;
        tq = '{QF, QF, QA, QA, QB, QB};
        te = '{4'h8, 4'h0, 4'h2, 4'h0, 4'h1, 4'h0};
        for (int i = 0; i < 6; i++) begin
            sb(tl[i], td[i], tq[i], tt[i]);
            sb(1'b1, 1'b0, 9'h000, 1'b0);
            rd(ceb_pkg::CAPTURE_OFS, {28'h0, te[i]});
            wr(ceb_pkg::CAPTURE_OFS, 32'h0000_0000);
        end
    endtask : t_events
    // identifier bits then checksum, the low bit spoiled when bad is set
    task t_frame(input logic [17:0] d, input logic [10:0] p11,
                 input logic [17:0] p18, input logic bad,
                 input logic [31:0] exp);
        logic [14:0] c;
        c = 15'h0000;
        id11_pattern <= p11;
        id18_pattern <= p18;
        fstart();
        for (int i = 17; i >= 0; i--) begin
            sb(1'b1, ~d[i], QC | Q18 | ((i > 6) ? Q11 : 9'h000), 1'b0);
            c = {c[13:0], 1'b0} ^ ((d[i] ^ c[14]) ? ceb_pkg::CRC_POLY : 15'h0);
        end
        c[0] = c[0] ^ bad;
        for (int i = 14; i >= 0; i--) begin
            sb(1'b1, ~c[i], QR, 1'b0);
        end
        sb(1'b1, 1'b0, QK, 1'b0);
        sb(1'b1, 1'b0, 9'h000, 1'b0);
        rd(ceb_pkg::CAPTURE_OFS, exp);
        wr(ceb_pkg::CAPTURE_OFS, 32'h0000_0000);
        rd(ceb_pkg::CAPTURE_OFS, 32'h0000_0000);
    endtask : t_frame
    // first bit after a change may be odd, so two bits are skipped
    task t_time(input logic [7:0] dv, input logic [4:0] s1,
                input logic [3:0] s2);
        int c, s;
        wr(ceb_pkg::TIMING_OFS, {8'h00, dv, 1'b0, s2, s1, 6'h00});
        rd(ceb_pkg::TIMING_OFS, {8'h00, dv, 1'b0, s2, s1, 6'h00});
        wt(1'b0);
        wt(1'b0);
        c = 0;
        s = 0;
        do begin
            @(posedge core_clk);
            c++;
            if (sample_point === 1'b1) s = c;
        end while (bit_end !== 1'b1 && c < 2000);
        check(32'(c), (32'(dv) + 1) * (32'(s1) + 32'(s2) + 3));
        check(32'(c - s), 32'((int'(s2) + 1) * (int'(dv) + 1)));
    endtask : t_time
    // ---------------------------------------------------------------
    // sequence and hang guard
    // ---------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        frame_start = 1'b0;
        tx_level = 1'b1;
        transmitting = 1'b0;
        node_dom = 1'b0;
        q = 9'h000;
        id11_pattern = 11'h000;
        id18_pattern = 18'h00000;
        err_count = 0;
        n_checks = 0;
        cyc = 0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_stuff();
        t_events();
        t_frame(18'h2A5C3, 11'h54B, 18'h2A5C2, 1'b0, 32'h0000_0000);
        t_frame(18'h2A5C3, 11'h54B, 18'h2A5C2, 1'b1, 32'h0000_0044);
        t_frame(18'h2A5C3, 11'h54A, 18'h2A5C3, 1'b1, 32'h0000_0024);
        t_time(8'h00, 5'h04, 4'h2);
        t_time(8'h01, 5'h02, 4'h1);
        t_time(8'h03, 5'h05, 4'h3);
        finish_test();
    end
endmodule : ceb_error_capture_tb
`default_nettype wire
